// ### rtl/link_regs_consts.svh
// constants for the link capabilities and link control registers
// assumes byte addressed configuration accesses on 32-bit words
`ifndef LINK_REGS_CONSTS_SVH
`define LINK_REGS_CONSTS_SVH

// register byte offsets in configuration space
`define CAP_OFFSET 12'h07C
`define CTRL_OFFSET 12'h080
`define ADDR_W 12
`define DATA_W 32
`define BE_W 4

// capabilities field values
`define PORT_NUM_VAL 8'h00
`define CAP_RSVD_VAL 5'h00
`define CLOCK_PM_CAPABLE_CAP_VAL 1'h1
`define ASPM_SUPPORT_VAL 2'h3
`define MAX_LANE_WIDTH_VAL 6'h01
`define MAX_SIGNAL_RATE_VAL 4'h2

// capabilities field positions
`define CAP_PORT_HI 31
`define CAP_PORT_LO 24
`define CAP_RSVD_HI 23
`define CAP_RSVD_LO 19
`define CAP_CLOCK_PM_CAPABLE_BIT 18
`define CAP_L1_HI 17
`define CAP_L1_LO 15
`define CAP_L0S_HI 14
`define CAP_L0S_LO 12
`define CAP_ASPM_HI 11
`define CAP_ASPM_LO 10
`define CAP_WIDTH_HI 9
`define CAP_WIDTH_LO 4
`define CAP_RATE_HI 3
`define CAP_RATE_LO 0

// link control layout
`define CTRL_W 16
`define CTRL_RESET 16'h0000
`define CTRL_WR_MASK 16'h01CB
`define CTRL_RSVD_HI 15
`define CTRL_RSVD_LO 9
`define CTRL_CPM_BIT 8
`define CTRL_ES_BIT 7
`define CTRL_CCC_BIT 6
`define CTRL_RETRAIN_BIT 5
`define CTRL_LINKOFF_BIT 4
`define CTRL_RCB_BIT 3
`define CTRL_RSVD2_BIT 2
`define CTRL_ASPM_HI 1
`define CTRL_ASPM_LO 0

`define LAT_W 3
`define LANE_W 8
`define WORD_ZERO 32'h00000000

`endif

// ### rtl/link_regs_pkg.sv
// types shared by the link register bank
// assumes the constants header is compiled alongside
package link_regs_pkg;

   // which register a configuration access hits
   typedef enum logic [1:0] {
      SEL_NONE = 2'h0,
      SEL_CAP = 2'h1,
      SEL_CTRL = 2'h3
   } reg_sel_type;

endpackage : link_regs_pkg

// ### rtl/link_cap_word.sv
// builds the read-only link capabilities word
// assumes the four latency settings are stable register outputs
`timescale 1ns/100ps
`include "link_regs_consts.svh"

module link_cap_word (
   input wire logic common_clk_i,
   input wire logic [`LAT_W-1:0] l1_time_separate_clock_i,
   input wire logic [`LAT_W-1:0] l1_time_shared_clock_i,
   input wire logic [`LAT_W-1:0] l0s_time_separate_clock_i,
   input wire logic [`LAT_W-1:0] l0s_time_shared_clock_i,
   output logic [`DATA_W-1:0] cap_word_o
);

   logic [`LAT_W-1:0] l1_exit_time_cap;
   logic [`LAT_W-1:0] l0s_exit_time_cap;

   // shared reference clock picks the common-clock latencies
   assign l1_exit_time_cap = common_clk_i ? l1_time_shared_clock_i
                                          : l1_time_separate_clock_i;
   assign l0s_exit_time_cap = common_clk_i ? l0s_time_shared_clock_i
                                           : l0s_time_separate_clock_i;

   // fixed fields plus the selected latencies
   assign cap_word_o = {`PORT_NUM_VAL,
                        `CAP_RSVD_VAL,
                        `CLOCK_PM_CAPABLE_CAP_VAL,
                        l1_exit_time_cap,
                        l0s_exit_time_cap,
                        `ASPM_SUPPORT_VAL,
                        `MAX_LANE_WIDTH_VAL,
                        `MAX_SIGNAL_RATE_VAL};

endmodule : link_cap_word

// ### rtl/link_regs.sv
// link capabilities and link control configuration registers
// assumes single-cycle configuration read and write strobes, 32-bit
// dword accesses with byte enables, and latency settings held elsewhere
//
// Behaviour
// - the port number field of the capabilities word reads zero.
// - reserved bits of both registers, including cap 23:19, control 15:9 and 2, read zero.
// - the clock power management capability bit is always one.
// - the L1 exit latency field shows the separate or shared clock L1 setting.
// - the L0s exit latency field shows the separate or shared clock L0s setting.
// - the active state PM support field reads binary 11.
// - the maximum lane width field reads 000001.
// - the maximum signal rate field reads 0010.
// - software sets the common clock bit, which steers the latency choice.
// - common clock zero reports the separate settings, one the shared ones.
// - the retrain request bit has no effect and reads zero.
// - the link off request bit has no effect and reads zero.
// - the two-bit active state PM control field is writable.
// - clock PM enable, extended sync and completion boundary bits are read/write.
// - the capabilities word reads 0004 plus the top two L1 latency bits in its upper half and 12 in its low byte.
`timescale 1ns/100ps
`include "link_regs_consts.svh"

module link_regs
   import link_regs_pkg::*;
#(
   parameter int LANES = `BE_W / 2
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic CFG_RD_I,
   input wire logic CFG_WR_I,
   input wire logic [`ADDR_W-1:0] CFG_ADDR_I,
   input wire logic [`BE_W-1:0] CFG_BE_I,
   input wire logic [`DATA_W-1:0] CFG_WDATA_I,
   input wire logic [`LAT_W-1:0] L1_TIME_SEPARATE_CLOCK_I,
   input wire logic [`LAT_W-1:0] L1_TIME_SHARED_CLOCK_I,
   input wire logic [`LAT_W-1:0] L0S_TIME_SEPARATE_CLOCK_I,
   input wire logic [`LAT_W-1:0] L0S_TIME_SHARED_CLOCK_I,
   output logic [`DATA_W-1:0] CFG_RDATA_O,
   output logic CFG_RVALID_O,
   output logic [1:0] ASPM_CONTROL_FIELD_O,
   output logic COMMON_CLOCK_O,
   output logic CLOCK_PM_ENABLE_O,
   output logic EXTENDED_SYNC_O,
   output logic READ_COMPLETION_BOUNDARY_O
);

   logic [`CTRL_W-1:0] ctrl_reg;
   logic [`CTRL_W-1:0] ctrl_next;
   logic [`DATA_W-1:0] cap_word;
   logic [`DATA_W-1:0] rdata_reg;
   logic [`DATA_W-1:0] rdata_next;
   logic rvalid_reg;
   reg_sel_type rd_sel;
   reg_sel_type wr_sel;
   reg_sel_type last_sel_reg;
   // a literal cannot be part-selected, so the mask gets a name first
   localparam logic [`CTRL_W-1:0] ctrl_wr_mask = `CTRL_WR_MASK;

   // word decode shared by the read and write paths
   function automatic reg_sel_type decode_sel(
      input logic [`ADDR_W-1:0] addr
   );
      reg_sel_type sel;
      sel = SEL_NONE;
      if ({addr[`ADDR_W-1:2], 2'b00} == `CAP_OFFSET) begin
         sel = SEL_CAP;
      end else if ({addr[`ADDR_W-1:2], 2'b00} == `CTRL_OFFSET) begin
         sel = SEL_CTRL;
      end
      return sel;
   endfunction : decode_sel

   assign rd_sel = CFG_RD_I ? decode_sel(CFG_ADDR_I) : SEL_NONE;
   assign wr_sel = CFG_WR_I ? decode_sel(CFG_ADDR_I) : SEL_NONE;

   // capabilities word follows the live common clock bit
   link_cap_word u_cap (
      .common_clk_i(ctrl_reg[`CTRL_CCC_BIT]),
      .l1_time_separate_clock_i(L1_TIME_SEPARATE_CLOCK_I),
      .l1_time_shared_clock_i(L1_TIME_SHARED_CLOCK_I),
      .l0s_time_separate_clock_i(L0S_TIME_SEPARATE_CLOCK_I),
      .l0s_time_shared_clock_i(L0S_TIME_SHARED_CLOCK_I),
      .cap_word_o(cap_word)
   );

   // per byte lane merge; only writable bits ever take data, so the
   // no-function and reserved bits stay zero whatever is written
   for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
      assign ctrl_next[lane*`LANE_W +: `LANE_W] =
         (wr_sel == SEL_CTRL && CFG_BE_I[lane])
         ? (CFG_WDATA_I[lane*`LANE_W +: `LANE_W]
            & ctrl_wr_mask[lane*`LANE_W +: `LANE_W])
         : ctrl_reg[lane*`LANE_W +: `LANE_W];
   end

   // link control storage; capabilities writes fall through untouched
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl_reg <= `CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // read mux; upper half of the control dword is not ours, reads zero
   always_comb begin
      rdata_next = `WORD_ZERO;
      unique case (rd_sel)
         SEL_CAP: rdata_next = cap_word;
         SEL_CTRL: rdata_next = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_reg};
         SEL_NONE: rdata_next = `WORD_ZERO;
         default: rdata_next = `WORD_ZERO;
      endcase
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rdata_reg <= `WORD_ZERO;
         rvalid_reg <= 1'b0;
         last_sel_reg <= SEL_NONE;
      end else begin
         rvalid_reg <= CFG_RD_I;
         last_sel_reg <= rd_sel;
         if (CFG_RD_I) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // control bits driven straight from storage
   assign CFG_RDATA_O = rdata_reg;
   assign CFG_RVALID_O = rvalid_reg;
   assign ASPM_CONTROL_FIELD_O = ctrl_reg[`CTRL_ASPM_HI:`CTRL_ASPM_LO];
   assign COMMON_CLOCK_O = ctrl_reg[`CTRL_CCC_BIT];
   assign CLOCK_PM_ENABLE_O = ctrl_reg[`CTRL_CPM_BIT];
   assign EXTENDED_SYNC_O = ctrl_reg[`CTRL_ES_BIT];
   assign READ_COMPLETION_BOUNDARY_O = ctrl_reg[`CTRL_RCB_BIT];

   // checks on the read answer of the capabilities word
   a_port_num_zero: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RD_I && decode_sel(CFG_ADDR_I) == SEL_CAP
      |=> CFG_RVALID_O && CFG_RDATA_O[`CAP_PORT_HI:`CAP_PORT_LO] == 8'h00)
      else $error("port number field not zero");

   a_cap_rsvd_zero: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CAP
      |-> CFG_RDATA_O[`CAP_RSVD_HI:`CAP_RSVD_LO] == 5'h00)
      else $error("capabilities reserved bits not zero");

   a_clock_pm_capable_set: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CAP
      |-> CFG_RDATA_O[`CAP_CLOCK_PM_CAPABLE_BIT])
      else $error("clock pm capability bit not set");

   a_l1_lat_select: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RD_I && decode_sel(CFG_ADDR_I) == SEL_CAP
      |=> CFG_RDATA_O[`CAP_L1_HI:`CAP_L1_LO] ==
          ($past(COMMON_CLOCK_O) ? $past(L1_TIME_SHARED_CLOCK_I)
                                 : $past(L1_TIME_SEPARATE_CLOCK_I)))
      else $error("l1 exit latency wrong source");

   a_l0s_lat_select: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RD_I && decode_sel(CFG_ADDR_I) == SEL_CAP
      |=> CFG_RDATA_O[`CAP_L0S_HI:`CAP_L0S_LO] ==
          ($past(COMMON_CLOCK_O) ? $past(L0S_TIME_SHARED_CLOCK_I)
                                 : $past(L0S_TIME_SEPARATE_CLOCK_I)))
      else $error("l0s exit latency wrong source");

   a_aspm_support: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CAP
      |-> CFG_RDATA_O[`CAP_ASPM_HI:`CAP_ASPM_LO] == 2'h3)
      else $error("aspm support field not 11");

   a_lane_width: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CAP
      |-> CFG_RDATA_O[`CAP_WIDTH_HI:`CAP_WIDTH_LO] == 6'h01)
      else $error("max lane width not one lane");

   a_signal_rate: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CAP
      |-> CFG_RDATA_O[`CAP_RATE_HI:`CAP_RATE_LO] == 4'h2)
      else $error("max signal rate not 0010");

   // checks on the link control register
   a_ctrl_rsvd_zero: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_RVALID_O && last_sel_reg == SEL_CTRL
      |-> CFG_RDATA_O[`DATA_W-1:`CTRL_RSVD_LO] == 23'h000000
          && !CFG_RDATA_O[`CTRL_RETRAIN_BIT]
          && !CFG_RDATA_O[`CTRL_LINKOFF_BIT]
          && !CFG_RDATA_O[`CTRL_RSVD2_BIT])
      else $error("control read-only bits not zero");

   a_aspm_write: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_WR_I && decode_sel(CFG_ADDR_I) == SEL_CTRL && CFG_BE_I[0]
      |=> ASPM_CONTROL_FIELD_O == $past(CFG_WDATA_I[1:0]))
      else $error("aspm control not written");

   a_rw_bits_write: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_WR_I && decode_sel(CFG_ADDR_I) == SEL_CTRL
      && CFG_BE_I[0] && CFG_BE_I[1]
      |=> CLOCK_PM_ENABLE_O == $past(CFG_WDATA_I[8])
          && EXTENDED_SYNC_O == $past(CFG_WDATA_I[7])
          && COMMON_CLOCK_O == $past(CFG_WDATA_I[6])
          && READ_COMPLETION_BOUNDARY_O == $past(CFG_WDATA_I[3]))
      else $error("read/write control bits not written");

   a_ro_write_drop: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      CFG_WR_I && decode_sel(CFG_ADDR_I) != SEL_CTRL
      |=> $stable(ctrl_reg))
      else $error("stray write altered link control");

endmodule : link_regs

// ### verification/testbench.sv
// self-checking bench for the link capabilities and link control registers
// assumes the design checks its own assertions; bench drives all ports
`timescale 1ns/100ps
`include "link_regs_consts.svh"

module testbench;
   import link_regs_pkg::*;
   logic SYS_CLK_I = 1'b0;
   logic RST_B_I = 1'b0;
   logic CFG_RD_I = 1'b0;
   logic CFG_WR_I = 1'b0;
   logic [`ADDR_W-1:0] CFG_ADDR_I = 12'h000;
   logic [`BE_W-1:0] CFG_BE_I = 4'h0;
   logic [`DATA_W-1:0] CFG_WDATA_I = 32'h00000000;
   logic [`LAT_W-1:0] l1_sep = 3'h6;
   logic [`LAT_W-1:0] l1_sh = 3'h3;
   logic [`LAT_W-1:0] l0s_sep = 3'h1;
   logic [`LAT_W-1:0] l0s_sh = 3'h5;
   logic [`DATA_W-1:0] CFG_RDATA_O;
   logic CFG_RVALID_O;
   logic [1:0] ASPM_CONTROL_FIELD_O;
   logic COMMON_CLOCK_O;
   logic CLOCK_PM_ENABLE_O;
   logic EXTENDED_SYNC_O;
   logic READ_COMPLETION_BOUNDARY_O;
   int error_cnt = 0;
   int compares = 0;
   logic [`DATA_W-1:0] rd;

   // 50 ns period, 20 MHz
   always #25 SYS_CLK_I = ~SYS_CLK_I;

   link_regs uut (
      .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
      .CFG_RD_I(CFG_RD_I), .CFG_WR_I(CFG_WR_I),
      .CFG_ADDR_I(CFG_ADDR_I), .CFG_BE_I(CFG_BE_I),
      .CFG_WDATA_I(CFG_WDATA_I),
      .L1_TIME_SEPARATE_CLOCK_I(l1_sep), .L1_TIME_SHARED_CLOCK_I(l1_sh),
      .L0S_TIME_SEPARATE_CLOCK_I(l0s_sep), .L0S_TIME_SHARED_CLOCK_I(l0s_sh),
      .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O),
      .ASPM_CONTROL_FIELD_O(ASPM_CONTROL_FIELD_O),
      .COMMON_CLOCK_O(COMMON_CLOCK_O),
      .CLOCK_PM_ENABLE_O(CLOCK_PM_ENABLE_O),
      .EXTENDED_SYNC_O(EXTENDED_SYNC_O),
      .READ_COMPLETION_BOUNDARY_O(READ_COMPLETION_BOUNDARY_O)
   );

   // verdict and end of run, reached from the main flow or a timeout
   task automatic complete_run;
      $display("errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // expected capabilities word built field by field
   function automatic logic [31:0] cap_exp(input logic [2:0] l1,
                                           input logic [2:0] l0s);
      return {8'h00, 5'h00, 1'b1, l1, l0s, 2'b11, 6'h01, 4'h2};
   endfunction : cap_exp

   // one-cycle write strobe, inputs moved on the falling edge
   task automatic cfg_write(input logic [11:0] a, input logic [3:0] be,
                            input logic [31:0] d);
      @(negedge SYS_CLK_I);
      CFG_WR_I = 1'b1;
      CFG_ADDR_I = a;
      CFG_BE_I = be;
      CFG_WDATA_I = d;
      @(negedge SYS_CLK_I);
      CFG_WR_I = 1'b0;
   endtask : cfg_write

   // one-cycle read strobe, then a bounded wait for the valid pulse
   task automatic cfg_read(input logic [11:0] a, output logic [31:0] d);
      @(negedge SYS_CLK_I);
      CFG_RD_I = 1'b1;
      CFG_ADDR_I = a;
      for (int i = 0; i < 4; i++) begin
         @(negedge SYS_CLK_I);
         CFG_RD_I = 1'b0;
         if (CFG_RVALID_O === 1'b1) begin
            d = CFG_RDATA_O;
            return;
         end
      end
      error_cnt++;
      $display("Error read valid expected 1 seen %b", CFG_RVALID_O);
      complete_run();
   endtask : cfg_read

   task automatic check_outputs(input logic [15:0] ctl);
      check("aspm out", ctl[1:0], ASPM_CONTROL_FIELD_O);
      check("common out", ctl[6], COMMON_CLOCK_O);
      check("cpm out", ctl[8], CLOCK_PM_ENABLE_O);
      check("es out", ctl[7], EXTENDED_SYNC_O);
      check("rcb out", ctl[3], READ_COMPLETION_BOUNDARY_O);
   endtask : check_outputs

   // values straight after reset, separate clock latencies selected
   task automatic scen_reset;
      check_outputs(16'h0000);
      cfg_read(`CAP_OFFSET, rd);
      check("cap reset", cap_exp(3'h6, 3'h1), rd);
      check("cap upper", 32'h0007, rd[31:16]);
      check("cap low byte", 32'h12, rd[7:0]);
      cfg_read(`CTRL_OFFSET, rd);
      check("ctrl reset", 32'h00000000, rd);
   endtask : scen_reset

   // all ones: reserved, retrain and link off bits must stay clear
   task automatic scen_all_ones;
      cfg_write(`CTRL_OFFSET, 4'hF, 32'hFFFFFFFF);
      cfg_read(`CTRL_OFFSET, rd);
      check("ctrl ones", 32'h000001CB, rd);
      check_outputs(16'h01CB);
      cfg_write(`CTRL_OFFSET, 4'h3, 32'h00000000);
      cfg_read(`CTRL_OFFSET, rd);
      check("ctrl cleared", 32'h00000000, rd);
      check_outputs(16'h0000);
   endtask : scen_all_ones

   // common clock bit steers both latency fields, inputs changed live
   task automatic scen_latency_select;
      cfg_write(`CTRL_OFFSET, 4'h1, 32'h00000040);
      cfg_read(`CAP_OFFSET, rd);
      check("cap shared", cap_exp(3'h3, 3'h5), rd);
      l1_sh = 3'h7;
      l0s_sh = 3'h0;
      cfg_read(`CAP_OFFSET, rd);
      check("cap shared2", cap_exp(3'h7, 3'h0), rd);
      cfg_write(`CTRL_OFFSET, 4'h1, 32'h00000000);
      l1_sep = 3'h2;
      cfg_read(`CAP_OFFSET, rd);
      check("cap separate", cap_exp(3'h2, 3'h1), rd);
   endtask : scen_latency_select

   // every active state PM control code written and read back
   task automatic scen_aspm_codes;
      for (int c = 0; c < 4; c++) begin
         cfg_write(`CTRL_OFFSET, 4'h1, 32'(c));
         cfg_read(`CTRL_OFFSET, rd);
         check("aspm code", 32'(c), rd);
         check("aspm pin", 32'(c), ASPM_CONTROL_FIELD_O);
      end
   endtask : scen_aspm_codes

   // byte lanes, read-only word, unmapped place; the low lane still
   // holds the last aspm code (3) left by the previous scenario
   task automatic scen_lanes_and_ro;
      cfg_write(`CTRL_OFFSET, 4'h2, 32'h0000FFFF);
      cfg_read(`CTRL_OFFSET, rd);
      check("upper lane only", 32'h00000103, rd);
      cfg_write(`CTRL_OFFSET, 4'h3, 32'h00000000);
      cfg_write(`CAP_OFFSET, 4'hF, 32'h00000000);
      cfg_read(`CAP_OFFSET, rd);
      check("cap after write", cap_exp(3'h2, 3'h1), rd);
      cfg_write(12'h084, 4'hF, 32'hFFFFFFFF);
      cfg_read(12'h084, rd);
      check("unmapped", 32'h00000000, rd);
      cfg_read(`CTRL_OFFSET, rd);
      check("ctrl untouched", 32'h00000000, rd);
   endtask : scen_lanes_and_ro

   // reset for 16 cycles, then the scenarios, then the reset checks once more after a second reset
   initial begin
      repeat (16) @(negedge SYS_CLK_I);
      RST_B_I = 1'b1;
      scen_reset();
      scen_all_ones();
      scen_latency_select();
      scen_aspm_codes();
      scen_lanes_and_ro();
      cfg_write(`CTRL_OFFSET, 4'h3, 32'h000001CB);
      @(negedge SYS_CLK_I);
      RST_B_I = 1'b0;
      l1_sep = 3'h6;
      @(negedge SYS_CLK_I);
      check_outputs(16'h0000);
      RST_B_I = 1'b1;
      scen_reset();
      complete_run();
   end
endmodule : testbench
